// ---- core/lph_core.sv ----
// Purpose: Primitive interpreter of the link controller.
// Assumes: Link events arrive as single-cycle pulses from same-clock logic.
// Notes: Self-test outcome is a parameterised result code.
`timescale 1ns/1ps
`include "lph_defs.svh"
module lph_core #(
  parameter logic [3:0] ST_RESULT = 4'h0
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Register port.
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Link events.
  input  wire logic        i_rx_reset_req,
  input  wire logic        i_rx_frmr,
  input  wire logic        i_rx_xid,
  input  wire logic        i_rx_test,
  input  wire logic        i_rx_xid_resp,
  input  wire logic        i_rx_disc,
  input  wire logic        i_tx_busy,
  // Link actions.
  output logic             o_tx_serial_line,
  output logic             o_tx_abort,
  output logic             o_link_disconnect,
  output logic             o_send_xid,
  output logic             o_send_resp,
  output logic             o_reject_ident,
  output logic             o_frmr_to_rx_desc,
  output logic             o_link_reset_ack,
  output logic             o_irq_enable,
  output logic             o_link_active
);
  import lph_pkg::*;

  localparam int ST_CYCLES = (`LPH_ST_RUN_NS + `LPH_CLK_NS - 1) / `LPH_CLK_NS;

  typedef struct packed {
    lph_phase_t  phase;
    logic        primitive_available;
    logic [3:0]  ppc;
    logic [3:0]  ppp;
    logic        fail;
    logic        ien;
    logic        ident_exchange_enable;
    logic        test_en;
    logic [7:0]  cnt;
    logic [15:0] rdata;
    logic        txl;
    logic        abort;
    logic        disc;
    logic        sxid;
    logic        sresp;
    logic        rej;
    logic        frmr_d;
    logic        rack;
    logic        act;
  } lph_state_t;

  lph_state_t st;
  lph_state_t next_st;

  // --------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------
  always_comb begin
    logic [3:0] up;
    logic       cmd;
    up = i_wdata[`LPH_BIT_USER_PRIMITIVE_CODE +: 4];
    cmd = i_wr && i_addr == `LPH_OFS_PRIM && i_wdata != `LPH_PAV_CLEAR;
    next_st = st;
    next_st.abort = 1'b0;
    next_st.disc = 1'b0;
    next_st.sxid = 1'b0;
    next_st.sresp = 1'b0;
    next_st.rej = 1'b0;
    next_st.frmr_d = 1'b0;
    next_st.rack = 1'b0;
    next_st.rdata = 16'h0000;
    if (i_wr && i_addr == `LPH_OFS_CTRL && st.phase != LPH_STOPPED) begin
      next_st.ien = i_wdata[`LPH_BIT_IEN];
    end
    if (i_wr && i_addr == `LPH_OFS_CFG) begin
      next_st.ident_exchange_enable = i_wdata[`LPH_BIT_IDENT_EXCHANGE_ENABLE];
    end
    if (i_wr && i_addr == `LPH_OFS_BUSCFG) begin
      next_st.test_en = i_wdata[`LPH_BIT_TEST];
    end
    if (i_wr && i_addr == `LPH_OFS_PRIM && i_wdata == `LPH_PAV_CLEAR) begin
      next_st.primitive_available = 1'b0;
    end
    if (cmd) begin
      case (up)
        `LPH_U_STOP: begin
          next_st.phase = LPH_STOPPED;
          next_st.ien = 1'b0;                  // [R14]
          next_st.abort = i_tx_busy;           // [R15]
        end
        `LPH_U_START: begin
          next_st.phase = LPH_IDLE;
        end
        `LPH_U_SELFTEST: begin
          if (st.test_en) begin
            next_st.phase = LPH_SELFTEST;
            next_st.cnt = 8'h00;
          end
        end
        `LPH_U_RST_RSP: begin
          if (st.phase != LPH_STOPPED) begin
            next_st.phase = LPH_RESETTING;
            next_st.rack = 1'b1;
          end
        end
        `LPH_U_XID_REQ: begin
          if (st.phase != LPH_STOPPED && st.ident_exchange_enable) begin
            next_st.sxid = 1'b1;               // [R08]
            next_st.phase = LPH_XID_WAIT;
          end
        end
        `LPH_U_XID_RSP, `LPH_U_TEST_RSP: begin
          next_st.sresp = st.phase != LPH_STOPPED;
        end
        `LPH_U_DISC: begin
          if (st.phase != LPH_STOPPED) begin
            next_st.disc = 1'b1;               // [R03]
            next_st.phase = LPH_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    if (st.phase == LPH_SELFTEST) begin
      next_st.cnt = st.cnt + 8'h01;
      if (int'(st.cnt) == ST_CYCLES - 1) begin
        next_st.phase = LPH_IDLE;
        next_st.primitive_available = 1'b1;                    // [R18]
        next_st.ppc = ST_RESULT;               // [R19]
        next_st.ppp = 4'h0;
        next_st.fail = ST_RESULT != `LPH_ST_PASS;
      end
    end else if (st.phase != LPH_STOPPED && !cmd) begin
      if (i_rx_reset_req) begin
        next_st.primitive_available = 1'b1;
        next_st.ppc = `LPH_P_RST_IND;          // [R01]
        next_st.ppp = 4'h0;
        next_st.phase = LPH_RESETTING;
      end else if (i_rx_disc) begin
        next_st.primitive_available = 1'b1;
        next_st.ppc = `LPH_P_DISC_IND;         // [R06]
        next_st.ppp = 4'h0;
        next_st.phase = LPH_IDLE;
      end else if (i_rx_frmr) begin
        next_st.primitive_available = 1'b1;
        next_st.ppc = `LPH_P_ERROR;            // [R04]
        next_st.ppp = `LPH_PARM_FRMR;
        next_st.frmr_d = 1'b1;                 // [R05]
      end else if (i_rx_xid_resp && st.phase == LPH_XID_WAIT) begin
        next_st.primitive_available = 1'b1;
        next_st.ppc = `LPH_P_XID_CNF;          // [R09]
        next_st.ppp = 4'h0;
        next_st.phase = LPH_RUN;
      end else if (i_rx_xid || i_rx_test) begin
        if (st.ident_exchange_enable) begin
          next_st.primitive_available = 1'b1;
          next_st.ppc = i_rx_xid ? `LPH_P_XID_IND : `LPH_P_TEST_IND; // [R10]
          next_st.ppp = 4'h0;
        end else begin
          next_st.rej = 1'b1;                  // [R12]
        end
      end
    end
    next_st.txl = next_st.phase == LPH_STOPPED || st.txl && st.phase == LPH_STOPPED; // [R13]
    next_st.act = next_st.phase != LPH_STOPPED && next_st.phase != LPH_SELFTEST;
    if (i_rd) begin
      case (i_addr)
        `LPH_OFS_CTRL: begin
          next_st.rdata[`LPH_BIT_STOP] = st.phase == LPH_STOPPED;  // [R14]
          next_st.rdata[`LPH_BIT_IEN] = st.ien;
        end
        `LPH_OFS_PRIM: begin
          next_st.rdata[3:0] = st.ppc;
          next_st.rdata[`LPH_BIT_TEST] = st.fail;  // [R18]
          next_st.rdata[`LPH_BIT_PAV] = st.primitive_available;
          next_st.rdata[11:8] = st.ppp;
        end
        `LPH_OFS_CFG: next_st.rdata[`LPH_BIT_IDENT_EXCHANGE_ENABLE] = st.ident_exchange_enable;
        default: next_st.rdata[`LPH_BIT_TEST] = st.test_en;
      endcase
    end
  end

  // --------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.phase <= LPH_STOPPED;
      st.txl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_tx_serial_line = st.txl;
  assign o_tx_abort = st.abort;
  assign o_link_disconnect = st.disc;
  assign o_send_xid = st.sxid;
  assign o_send_resp = st.sresp;
  assign o_reject_ident = st.rej;
  assign o_frmr_to_rx_desc = st.frmr_d;
  assign o_link_reset_ack = st.rack;
  assign o_irq_enable = st.ien;
  assign o_link_active = st.act;

  // --------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_stop_cmd;
    i_wr && i_addr == `LPH_OFS_PRIM && i_wdata[11:8] == `LPH_U_STOP
      && i_wdata != `LPH_PAV_CLEAR;
  endsequence

  chk_stop_line_high: assert property (s_stop_cmd |=> o_tx_serial_line [*2]) // [R13]
    else $error("Transmit line not high while stopped.");
  chk_stop_irq_off: assert property (s_stop_cmd |=> !o_irq_enable) // [R14]
    else $error("Interrupts still enabled after stop.");
  chk_stop_abort: assert property (s_stop_cmd ##0 i_tx_busy |=> o_tx_abort) // [R15]
    else $error("Busy frame not aborted on stop.");
  chk_reset_ind: assert property (o_link_active && !st.primitive_available && i_rx_reset_req && !i_wr
      && !(st.phase == LPH_SELFTEST) |=> st.primitive_available && st.ppc == 4'h8) // [R01]
    else $error("Reset indication not posted.");
  chk_frmr_post: assert property (o_frmr_to_rx_desc |-> st.ppc == 4'h4 && st.ppp == 4'h2) // [R04]
    else $error("FRMR error indication wrong.");
  chk_frmr_desc: assert property ($rose(st.ppp == 4'h2) && st.ppc == 4'h4 |-> o_frmr_to_rx_desc) // [R05]
    else $error("FRMR info not stored.");
  chk_ident_refuse: assert property (o_reject_ident |-> !$past(st.ident_exchange_enable) && $stable(st.ppc)) // [R12]
    else $error("Refused frame posted an indication.");
  chk_ident_post: assert property (o_link_active && st.ident_exchange_enable && i_rx_test && !i_rx_reset_req
      && !i_rx_disc && !i_rx_frmr && !i_wr |=> st.ppc == 4'hc) // [R10]
    else $error("TEST indication not posted.");
  chk_xid_conf: assert property (st.phase == LPH_XID_WAIT && i_rx_xid_resp && !i_rx_reset_req
      && !i_rx_disc && !i_rx_frmr && !i_wr |=> st.ppc == 4'hb && st.primitive_available) // [R09]
    else $error("XID confirmation not posted.");
  chk_disc_cmd: assert property (i_wr && i_addr == `LPH_OFS_PRIM && i_wdata[11:8] == 4'he
      && o_link_active |=> o_link_disconnect) // [R03]
    else $error("Disconnect not issued.");
  chk_test_done: assert property (st.phase == LPH_SELFTEST && int'(st.cnt) == ST_CYCLES - 1
      |=> st.primitive_available && st.fail == (ST_RESULT != 4'h0)) // [R18]
    else $error("Self test did not complete properly.");
  chk_test_code: assert property ($rose(st.primitive_available) && $past(st.phase) == LPH_SELFTEST
      |-> st.ppc == ST_RESULT) // [R19]
    else $error("Self test code wrong.");
endmodule // lph_core

// ---- core/lph_defs.svh ----
// Purpose: Constants of the link primitive handler.
// Assumes: 200 MHz system clock.
// Notes: Offsets are word indices on the plain register port.
// Contract
// [R01] Remote link reset posts provided code 8.
// [R02] Host answers reset or FRMR with 9.
// [R03] Code 14 from host disconnects the link.
// [R04] Received FRMR posts code 4, parameter 2.
// [R05] FRMR info goes to next receive descriptor.
// [R06] After reset response, await reset or disconnect.
// [R07] Host sets exchange enable before any exchange.
// [R08] Host fills transmit buffer, then issues 10.
// [R09] Remote exchange answer posts code 11.
// [R10] XID posts 10, TEST posts 12, stored.
// [R11] Host answers XID with 11, TEST 13.
// [R12] Exchange disabled: refuse frames, post nothing.
// [R13] Stopped: no traffic, transmit line held high.
// [R14] Stop sets stop bit, disables interrupts.
// [R15] Frame in transmission when stopping is aborted.
// [R16] Restart repeats initialization, may skip steps.
// [R17] Self test: reset, bus bit 4, code 5.
// [R18] Test done sets available flag, bit 4 result.
// [R19] Result 0 pass, 1 to 6 areas.
// [R20] Host times out self test at 75 ms.
// [R21] Pass may rerun at once; failure needs reset.
// [R22] Host should reset after any self test.
// [R23] Host clears available flag writing 0040h.
// [R24] Host issues next primitive after flag cleared.
`ifndef LPH_DEFS_SVH
`define LPH_DEFS_SVH
`define LPH_OFS_CTRL       2'h0
`define LPH_OFS_PRIM       2'h1
`define LPH_OFS_CFG        2'h2
`define LPH_OFS_BUSCFG     2'h3
`define LPH_BIT_STOP       2
`define LPH_BIT_IEN        6
`define LPH_BIT_IDENT_EXCHANGE_ENABLE       0
`define LPH_BIT_TEST       4
`define LPH_BIT_PAV        6
`define LPH_BIT_USER_PRIMITIVE_CODE      8
`define LPH_PAV_CLEAR      16'h0040
`define LPH_U_INIT         4'h2
`define LPH_U_START        4'h3
`define LPH_U_STOP         4'h1
`define LPH_U_SELFTEST     4'h5
`define LPH_U_RST_RSP      4'h9
`define LPH_U_XID_REQ      4'ha
`define LPH_U_XID_RSP      4'hb
`define LPH_U_TEST_RSP     4'hd
`define LPH_U_DISC         4'he
`define LPH_P_ERROR        4'h4
`define LPH_P_RST_IND      4'h8
`define LPH_P_XID_IND      4'ha
`define LPH_P_XID_CNF      4'hb
`define LPH_P_TEST_IND     4'hc
`define LPH_P_DISC_IND     4'he
`define LPH_PARM_FRMR      4'h2
`define LPH_ST_PASS        4'h0
`define LPH_ST_RUN_NS      64
`define LPH_CLK_NS         5
`endif

// ---- core/lph_pkg.sv ----
// Purpose: Types of the link primitive handler.
// Assumes: Included constants header.
// Notes: None.
package lph_pkg;
  typedef enum logic [2:0] {
    LPH_STOPPED,
    LPH_IDLE,
    LPH_RUN,
    LPH_RESETTING,
    LPH_XID_WAIT,
    LPH_SELFTEST
  } lph_phase_t;
endpackage

// ---- tb/lph_host.sv ----
// Purpose: Host model that drives the register port of the handler.
// Assumes: One clock; strobes last one cycle.
// Notes: Tasks return just after the edge that samples the strobe.
`timescale 1ns/1ps
module lph_host (
  // Clock and read data.
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  // Register port.
  output logic      [1:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr  = 2'h0;
    o_wdata = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_mclk);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule // lph_host

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the primitive handler.
// Assumes: Host model issues every primitive.
// Notes: Outputs are looked at 1 ns after the edge that makes them.
`timescale 1ns/1ps
`include "lph_defs.svh"
module tb;
  import lph_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic busy = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, d;
  logic wr, rd, tx, abrt, disc, sx, sr, rej, frd, rack, irq, act;
  int num_errors = 0;
  int checked = 0;
  always #2.5 i_mclk = ~i_mclk;
  lph_host host (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
                 .o_wr(wr), .o_rd(rd));
  lph_core DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_reset_req(ev[0]), .i_rx_frmr(ev[1]),
    .i_rx_xid(ev[2]), .i_rx_test(ev[3]), .i_rx_xid_resp(ev[4]), .i_rx_disc(ev[5]),
    .i_tx_busy(busy), .o_tx_serial_line(tx), .o_tx_abort(abrt), .o_link_disconnect(disc),
    .o_send_xid(sx), .o_send_resp(sr), .o_reject_ident(rej), .o_frmr_to_rx_desc(frd),
    .o_link_reset_ack(rack), .o_irq_enable(irq), .o_link_active(act));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge i_mclk);
    ev[i] <= 1'b1;
    @(posedge i_mclk);
    ev <= 6'h00;
    #1;
  endtask
  // Reads the primitive register, compares the masked value, then clears the flag.
  task automatic prim(input logic [15:0] m, input logic [15:0] exp);
    host.rd(`LPH_OFS_PRIM, d);
    chk(d & m, exp);
    host.wr(`LPH_OFS_PRIM, `LPH_PAV_CLEAR);
  endtask
  task automatic give_verdict;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk(tx, 1'b1);
    host.wr(`LPH_OFS_PRIM, 16'h0300);
    host.wr(`LPH_OFS_CTRL, 16'h0040);
    chk({tx, irq, act}, 3'b011);
    $display("test start done");
    pulse(0);
    prim(16'h005f, 16'h0048);
    host.wr(`LPH_OFS_PRIM, 16'h0900);
    chk(rack, 1'b1);
    pulse(1);
    chk(frd, 1'b1);
    prim(16'h0f5f, 16'h0244);
    host.wr(`LPH_OFS_PRIM, 16'h0e00);
    chk(disc, 1'b1);
    $display("test reset and error done");
    host.wr(`LPH_OFS_CFG, 16'h0000);
    pulse(2);
    chk(rej, 1'b1);
    prim(16'h0040, 16'h0000);
    host.wr(`LPH_OFS_CFG, 16'h0001);
    pulse(2);
    prim(16'h005f, 16'h004a);
    host.wr(`LPH_OFS_PRIM, 16'h0b00);
    chk(sr, 1'b1);
    pulse(3);
    prim(16'h005f, 16'h004c);
    host.wr(`LPH_OFS_PRIM, 16'h0d00);
    chk(sr, 1'b1);
    host.wr(`LPH_OFS_PRIM, 16'h0a00);
    chk(sx, 1'b1);
    pulse(4);
    prim(16'h005f, 16'h004b);
    $display("test ident exchange done");
    busy <= 1'b1;
    host.wr(`LPH_OFS_PRIM, 16'h0100);
    chk({abrt, tx, irq, act}, 4'b1100);
    busy <= 1'b0;
    host.rd(`LPH_OFS_CTRL, d);
    chk(d & 16'h0044, 16'h0004);
    pulse(2);
    chk({tx, act}, 2'b10);
    $display("test stop done");
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    host.wr(`LPH_OFS_BUSCFG, 16'h0010);
    for (int k = 0; k < 2; k++) begin
      host.wr(`LPH_OFS_PRIM, 16'h0500);
      d = 16'h0000;
      for (int n = 0; n < 30 && d[6] !== 1'b1; n++) host.rd(`LPH_OFS_PRIM, d);
      chk(d & 16'h005f, 16'h0040);
      host.wr(`LPH_OFS_PRIM, `LPH_PAV_CLEAR);
    end
    $display("test self test done");
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    host.wr(`LPH_OFS_PRIM, 16'h0300);
    chk(act, 1'b1);
    give_verdict();
  end
endmodule // tb
